/* File: src/controller_external_bus_port.sv */
// multiplexed external bus port with watchdog fault and valve safety logic
// Functional notes
// RULE_01: each fetch starts with both strobes high, then fetch address on the bus.
// RULE_02: falling address latch strobe captures low 8 address bits externally.
// RULE_03: upper 5 fetch address bits stay on high port until byte read.
// RULE_04: program strobe low enables memory; byte sampled one machine state later.
// RULE_05: fetch cycles repeat back to back, broken only by data accesses.
// RULE_06: no address latch or program strobe pulse during data access.
// RULE_07: read or write strobe held low while data moves on the bus.
// RULE_08: reset input held high at least 24 oscillator periods at power-up.
// RULE_09: watchdog fault line going low raises the interrupt request.
// RULE_10: timing fault cuts valve power; serviced interrupt shows code and alarm.
// RULE_11: help codes 0,4,5,6,7,8,9 report specific hardware faults.
// RULE_12: valves fall to de-energised safe state on any hardware failure.
// RULE_13: supply switch sampled periodically; no inflate without supply pressure.
// RULE_14: external latch transparent while strobe high, holding while low.
`timescale 1ns/1ps
`default_nettype none
module controller_external_bus_port
  import ext_bus_pkg::*;
#(
  parameter int STATE_CYCLES = STATE_CLKS,
  parameter int SAMPLE_CYCLES = PSW_SAMPLE_CLKS
) (
  input wire logic clk, // 250 MHz system clock
  input wire logic rst, // synchronous reset, active high
  output bus_pins_s bus_o, // strobes, high port and bus drive
  input wire logic [AD_W-1:0] ad_i, // multiplexed bus level
  input wire logic [FETCH_AW-1:0] fetch_addr, // address of the next program byte
  output logic [AD_W-1:0] instr, // fetched program byte
  output logic instr_valid, // one-cycle pulse with instr
  input wire logic req_valid, // external data access request
  output logic req_ready, // request taken at this edge when valid
  input wire data_req_s req, // access kind, address and write data
  output logic [AD_W-1:0] rdata, // data read from the bus
  output logic rdata_valid, // one-cycle pulse with rdata
  input wire logic timer_fault_n, // watchdog fault pin, active low
  output logic irq, // pending interrupt request level
  input wire logic irq_ack, // interrupt service pulse
  input wire logic fault_report, // pulse: report fault_code
  input wire logic [CODE_W-1:0] fault_code, // help code to report
  output logic [CODE_W-1:0] help_code, // displayed help code
  output logic help_show, // help code on display
  output logic alarm_tone, // alarm tone request
  input wire logic supply_ok_pin, // supply pressure switch pin
  input wire logic [VALVE_W-1:0] valve_req, // requested valve energise pattern
  output logic [VALVE_W-1:0] valve, // valve drive, high energises
  output logic valve_power_en // valve relay enable
);
  localparam int CW = $clog2(STATE_CYCLES + 1);
  localparam int PW = $clog2(SAMPLE_CYCLES + 1);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (STATE_CYCLES < 1 || SAMPLE_CYCLES < 1) begin : g_chk
    $error("state and sample lengths must be at least one cycle");
  end

  // ****************************************
  // machine state sequencer
  // ****************************************
  bus_state_e st_q;
  logic [CW-1:0] cnt_q;
  logic last;
  logic [FETCH_AW-1:0] faddr_q;
  data_req_s dreq_q;

  assign last = (cnt_q == CW'(STATE_CYCLES - 1));
  // a data access may only slot in at the end of a completed fetch
  assign req_ready = last && (st_q == ST_F_SAMPLE); // RULE_05

  // every state lasts one machine state
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (last) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // fetch loop, left only for a pending data access
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_F_ADDR;
    end else if (last) begin
      unique case (st_q)
        ST_F_ADDR: st_q <= ST_F_LATCH;
        ST_F_LATCH: st_q <= ST_F_OE;
        ST_F_OE: st_q <= ST_F_SAMPLE;
        ST_F_SAMPLE: st_q <= req_valid ? ST_D_ADDR : ST_F_ADDR; // RULE_05
        ST_D_ADDR: st_q <= ST_D_STROBE;
        ST_D_STROBE: st_q <= ST_D_END;
        ST_D_END: st_q <= ST_F_ADDR;
      endcase
    end
  end

  // fetch address is taken only between fetches so it holds until the byte is in
  always_ff @(posedge clk) begin
    if (rst) begin
      faddr_q <= '0;
    end else if (last && (st_q == ST_F_SAMPLE || st_q == ST_D_END)) begin
      faddr_q <= fetch_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dreq_q <= '0;
    end else if (req_valid && req_ready) begin
      dreq_q <= req;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // strobes come from flops so the pins never glitch between states
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_o <= '{ale: 1'b1, program_store_strobe: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                 ad_oe: 1'b0, ad_o: AD_IDLE, a_hi: HI_IDLE};
    end else begin
      bus_o.rd_n <= 1'b1;
      bus_o.wr_n <= 1'b1;
      unique case (st_q)
        ST_F_ADDR: begin
          bus_o.ale <= 1'b1; // RULE_01
          bus_o.program_store_strobe <= 1'b1; // RULE_01
          bus_o.ad_oe <= 1'b1;
          bus_o.ad_o <= faddr_q[AD_W-1:0]; // RULE_01
          bus_o.a_hi <= HI_W'(faddr_q[FETCH_AW-1:AD_W]); // RULE_03
        end
        ST_F_LATCH: begin
          // low byte still driven as the strobe falls, so the latch closes on it
          bus_o.ale <= 1'b0; // RULE_02 RULE_14
          bus_o.ad_oe <= 1'b1;
        end
        ST_F_OE, ST_F_SAMPLE: begin
          bus_o.ad_oe <= 1'b0;
          bus_o.program_store_strobe <= 1'b0; // RULE_04
        end
        ST_D_ADDR: begin
          bus_o.ale <= 1'b0; // RULE_06
          bus_o.program_store_strobe <= 1'b1; // RULE_06
          bus_o.ad_oe <= 1'b1;
          bus_o.ad_o <= dreq_q.addr[AD_W-1:0];
          bus_o.a_hi <= dreq_q.addr[DATA_AW-1:AD_W];
        end
        ST_D_STROBE: begin
          bus_o.rd_n <= dreq_q.we; // RULE_07
          bus_o.wr_n <= !dreq_q.we; // RULE_07
          bus_o.ad_oe <= dreq_q.we;
          bus_o.ad_o <= dreq_q.wdata;
        end
        ST_D_END: begin
          bus_o.ad_oe <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // bus sampling
  // ****************************************
  // memory has had a full machine state of output enable before the sample
  always_ff @(posedge clk) begin
    if (rst) begin
      instr <= AD_IDLE;
      instr_valid <= 1'b0;
    end else begin
      instr_valid <= last && (st_q == ST_F_SAMPLE); // RULE_04
      if (last && st_q == ST_F_SAMPLE) begin
        instr <= ad_i; // RULE_04
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= AD_IDLE;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= last && (st_q == ST_D_STROBE) && !dreq_q.we;
      if (last && st_q == ST_D_STROBE && !dreq_q.we) begin
        rdata <= ad_i; // RULE_07
      end
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic fault_n_s, supply_s, fault_n_prev_q;

  pin_sync3 #(.WIDTH(2), .INIT(2'b10)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({timer_fault_n, supply_ok_pin}),
    .q({fault_n_s, supply_s})
  );

  // ****************************************
  // watchdog interrupt and help codes
  // ****************************************
  logic fault_fall, fault_q;
  assign fault_fall = fault_n_prev_q && !fault_n_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_n_prev_q <= 1'b1;
    end else begin
      fault_n_prev_q <= fault_n_s;
    end
  end

  // a new fall in the ack cycle keeps the request pending
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (fault_fall) begin
      irq <= 1'b1; // RULE_09
    end else if (irq_ack) begin
      irq <= 1'b0;
    end
  end

  // the fault is latched until reset, matching the non-recoverable external timer
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (!fault_n_s) begin
      fault_q <= 1'b1; // RULE_10
    end
  end

  // help codes stay on display with a steady tone once shown
  always_ff @(posedge clk) begin
    if (rst) begin
      help_code <= HELP_CAL;
      help_show <= 1'b0;
      alarm_tone <= 1'b0;
    end else if (irq && irq_ack) begin
      help_code <= HELP_TIMER; // RULE_10 RULE_11
      help_show <= 1'b1;
      alarm_tone <= 1'b1; // RULE_10
    end else if (fault_report && !help_show) begin
      help_code <= fault_code; // RULE_11
      help_show <= 1'b1;
      alarm_tone <= 1'b1;
    end
  end

  // ****************************************
  // supply switch sampling and valves
  // ****************************************
  logic [PW-1:0] smp_q;
  logic supply_q;

  // periodic look at the switch, so a bouncing contact cannot chatter the inflate valve
  always_ff @(posedge clk) begin
    if (rst) begin
      smp_q <= '0;
      supply_q <= 1'b0;
    end else if (smp_q == PW'(SAMPLE_CYCLES - 1)) begin
      smp_q <= '0;
      supply_q <= supply_s; // RULE_13
    end else begin
      smp_q <= smp_q + PW'(1);
    end
  end

  // any failure drops every valve to its unpowered, cuff-sealing state
  always_ff @(posedge clk) begin
    if (rst) begin
      valve <= '0;
      valve_power_en <= 1'b0;
    end else if (fault_q || !fault_n_s || help_show) begin
      valve <= '0; // RULE_12
      valve_power_en <= 1'b0; // RULE_10 RULE_12
    end else begin
      valve <= valve_req;
      valve[VALVE_INFLATE] <= valve_req[VALVE_INFLATE] && supply_q; // RULE_13
      valve_power_en <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: src/ext_bus_pkg.sv */
// shared constants and carriers for the external bus port
package ext_bus_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_NS = 4;
  localparam int STATE_NS = 8; // length of one machine state
  localparam int STATE_CLKS = (STATE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_HOLD_PERIODS = 24; // least power-up reset hold, oscillator periods
  localparam int PSW_SAMPLE_US = 4; // supply switch sampling interval
  localparam int PSW_SAMPLE_CLKS = (PSW_SAMPLE_US * 1000) / CLK_NS;

  // ****************************************
  // widths and field positions
  // ****************************************
  localparam int AD_W = 8;
  localparam int HI_W = 8;
  localparam int FETCH_HI_W = 5; // upper fetch address bits on the high port
  localparam int FETCH_AW = AD_W + FETCH_HI_W;
  localparam int DATA_AW = AD_W + HI_W;
  localparam int VALVE_W = 6;
  localparam int VALVE_INFLATE = 0; // inflate valve position in the valve word
  localparam int CODE_W = 4;

  // ****************************************
  // help codes
  // ****************************************
  localparam logic [CODE_W-1:0] HELP_CAL = 4'h0;
  localparam logic [CODE_W-1:0] HELP_VALVE = 4'h4;
  localparam logic [CODE_W-1:0] HELP_ANALOG = 4'h5;
  localparam logic [CODE_W-1:0] HELP_TIMER = 4'h6;
  localparam logic [CODE_W-1:0] HELP_BCD = 4'h7;
  localparam logic [CODE_W-1:0] HELP_ROM = 4'h8;
  localparam logic [CODE_W-1:0] HELP_RAM = 4'h9;

  // ****************************************
  // reset values of the pins
  // ****************************************
  localparam logic [AD_W-1:0] AD_IDLE = 8'h00;
  localparam logic [HI_W-1:0] HI_IDLE = 8'h00;

  // ****************************************
  // carriers
  // ****************************************
  typedef enum logic [2:0] {
    ST_F_ADDR, ST_F_LATCH, ST_F_OE, ST_F_SAMPLE, ST_D_ADDR, ST_D_STROBE, ST_D_END
  } bus_state_e;

  typedef struct packed {
    logic ale; // address latch strobe, high latches open
    logic program_store_strobe; // low enables program memory outputs
    logic rd_n;
    logic wr_n;
    logic ad_oe; // high while this end drives the multiplexed bus
    logic [AD_W-1:0] ad_o;
    logic [HI_W-1:0] a_hi;
  } bus_pins_s;

  typedef struct packed {
    logic we;
    logic [DATA_AW-1:0] addr;
    logic [AD_W-1:0] wdata;
  } data_req_s;

endpackage

/* File: src/pin_sync3.sv */
// three-stage pin synchroniser with second/third agreement
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] d, // asynchronous pin level
  output logic [WIDTH-1:0] q // settled level
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q;

  // first stage is read only by the second, so metastability stays contained
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once two later stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= INIT;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/ext_bus_checker.sv */
// concurrent checks on the external bus port pins
`timescale 1ns/1ps
`default_nettype none
module ext_bus_checker
  import ext_bus_pkg::*;
#(
  parameter int STATE_CYCLES = 2,
  parameter int SAMPLE_CYCLES = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire bus_pins_s bus_o, // bus pins
  input wire logic [AD_W-1:0] ad_i, // bus level
  input wire logic [AD_W-1:0] instr, // fetched byte
  input wire logic instr_valid, // fetch done
  input wire logic [AD_W-1:0] rdata, // read byte
  input wire logic rdata_valid, // read done
  input wire logic timer_fault_n, // watchdog pin
  input wire logic irq, // interrupt level
  input wire logic irq_ack, // service pulse
  input wire logic [CODE_W-1:0] help_code, // shown code
  input wire logic help_show, // code shown
  input wire logic alarm_tone, // tone request
  input wire logic [VALVE_W-1:0] valve, // valve drive
  input wire logic valve_power_en // relay enable
);
  // ****************
  // bus and fault properties
  // ****************
  // figures below assume a two-clock machine state
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_fetch_open; $rose(bus_o.ale) |-> bus_o.program_store_strobe && bus_o.ad_oe; endproperty
  a_fetch_open: assert property (p_fetch_open) else $error("fetch start");
  property p_latch_cap; $fell(bus_o.ale) |-> bus_o.ad_oe && $stable(bus_o.ad_o); endproperty
  a_latch_cap: assert property (p_latch_cap) else $error("latch address");
  property p_high_hold;
    $rose(bus_o.ale) |-> bus_o.a_hi[7:5] == 3'h0 ##1 $stable(bus_o.a_hi) [*6];
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high port");
  // the memory and the port must never drive the bus together
  property p_byte_sample; $fell(bus_o.program_store_strobe) |-> !bus_o.ad_oe
    ##3 (instr_valid && instr == $past(ad_i)); endproperty
  a_byte_sample: assert property (p_byte_sample) else $error("byte sample");
  property p_fetch_repeat; $fell(bus_o.ale) |-> ##[6:12] $rose(bus_o.ale); endproperty
  a_fetch_repeat: assert property (p_fetch_repeat) else $error("fetch gap");
  property p_data_quiet; !(bus_o.rd_n && bus_o.wr_n) |-> !bus_o.ale && bus_o.program_store_strobe;
  endproperty
  a_data_quiet: assert property (p_data_quiet) else $error("strobe in data");
  // the read byte is taken at the end of the first strobe cycle and shows in the second
  property p_read; $fell(bus_o.rd_n) |-> !bus_o.ad_oe
    ##1 (!bus_o.rd_n && rdata_valid && rdata == $past(ad_i)) ##1 bus_o.rd_n; endproperty
  a_read: assert property (p_read) else $error("read strobe");
  property p_fault_irq; $fell(timer_fault_n) |-> ##[2:6] irq; endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("no interrupt");
  property p_service; irq && irq_ack |=> help_code == HELP_TIMER && help_show && alarm_tone;
  endproperty
  a_service: assert property (p_service) else $error("service");
  property p_safe; help_show |=> valve == '0 && !valve_power_en; endproperty
  a_safe: assert property (p_safe) else $error("valves live");
endmodule
bind controller_external_bus_port ext_bus_checker #(.STATE_CYCLES(STATE_CYCLES),
  .SAMPLE_CYCLES(SAMPLE_CYCLES)) u_ext_bus_checker (.clk, .rst, .bus_o, .ad_i, .instr,
  .instr_valid, .rdata, .rdata_valid, .timer_fault_n, .irq, .irq_ack, .help_code,
  .help_show, .alarm_tone, .valve, .valve_power_en);
`default_nettype wire

/* File: verif/ext_program_memory.sv */
// program memory with its address latch on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module ext_program_memory
  import ext_bus_pkg::*;
(
  input wire bus_pins_s pins, // strobes and high port
  input wire logic [AD_W-1:0] ad, // resolved bus
  output logic oe, // memory drives the bus
  output logic [AD_W-1:0] data // code byte
);
  // ****************
  // latch and store
  // ****************
  logic [AD_W-1:0] lat;
  // open while the strobe is high, so its fall freezes the low byte
  always_latch begin
    if (pins.ale) begin
      lat <= ad;
    end
  end
  // an xor pattern stands in for code, so a wrong address shows
  assign oe = !pins.program_store_strobe;
  assign data = lat ^ {pins.a_hi[4:0], 3'h0} ^ 8'h3c;
endmodule
`default_nettype wire

/* File: verif/tb_controller_external_bus_port.sv */
// self-checking bench for the external bus port
`timescale 1ns/1ps
`default_nettype none
module tb_controller_external_bus_port
  import ext_bus_pkg::*;
;
  // ****************
  // design and partner
  // ****************
  logic clk, rst, req_valid, req_ready, timer_fault_n, irq, irq_ack, fault_report;
  logic help_show, alarm_tone, supply_ok_pin, valve_power_en, instr_valid, rdata_valid, mem_oe;
  bus_pins_s bus_o;
  data_req_s req;
  logic [AD_W-1:0] ad_i, instr, rdata, mem_data, periph, wr_seen, hi_seen;
  logic [FETCH_AW-1:0] fetch_addr;
  logic [CODE_W-1:0] fault_code, help_code;
  logic [VALVE_W-1:0] valve_req, valve;
  int n_mismatch, cmp_count, cyc;
  controller_external_bus_port #(.SAMPLE_CYCLES(8)) u_controller_external_bus_port (.clk,
    .rst, .bus_o, .ad_i, .fetch_addr, .instr, .instr_valid, .req_valid, .req_ready, .req,
    .rdata, .rdata_valid, .timer_fault_n, .irq, .irq_ack, .fault_report, .fault_code,
    .help_code, .help_show, .alarm_tone, .supply_ok_pin, .valve_req, .valve, .valve_power_en);
  ext_program_memory u_ext_program_memory (.pins(bus_o), .ad(ad_i), .oe(mem_oe), .data(mem_data));
  // an undriven bus wobbles so a stale value cannot pass
  assign ad_i = bus_o.ad_oe ? bus_o.ad_o : mem_oe ? mem_data :
    !bus_o.rd_n ? periph : (cyc[0] ? 8'h5a : 8'ha5);
  // ****************
  // clock, monitor, timeout
  // ****************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!(bus_o.rd_n && bus_o.wr_n)) hi_seen <= bus_o.a_hi;
    if (!bus_o.wr_n) wr_seen <= bus_o.ad_o;
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait at falling edges, where outputs are settled
  task automatic wait_for(input int w);
    int n;
    n = 0;
    while (n < 80 && (w == 0 ? instr_valid : w == 1 ? rdata_valid : w == 2 ? req_ready : irq)
      !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    if (n == 80) n_mismatch++;
  endtask
  // reset held for at least the least power-up hold, so the port always starts clean
  task automatic do_reset();
    rst = 1'b1;
    repeat (RST_HOLD_PERIODS) @(negedge clk);
    rst = 1'b0;
  endtask
  // ****************
  // scenarios
  // ****************
  // the second byte is the first sure to use the new address
  task automatic t_fetch(input logic [FETCH_AW-1:0] a);
    fetch_addr = a;
    repeat (3) begin
      @(negedge clk);
      wait_for(0);
    end
    chk(instr, a[7:0] ^ {a[12:8], 3'h0} ^ 8'h3c);
  endtask
  // request held until taken, then dropped
  task automatic t_access(input logic we, input logic [15:0] addr, input logic [7:0] d);
    req = '{we, addr, d};
    periph = d;
    req_valid = 1'b1;
    wait_for(2);
    @(negedge clk);
    req_valid = 1'b0;
    if (!we) wait_for(1);
    else repeat (6) @(negedge clk);
    chk(we ? wr_seen : rdata, d);
    chk(hi_seen, addr[15:8]);
  endtask
  task automatic t_supply();
    repeat (40) @(negedge clk);
    chk({valve_power_en, valve}, 16'h007f);
    supply_ok_pin = 1'b0;
    repeat (40) @(negedge clk);
    chk(valve, 6'h3f & ~(6'h01 << VALVE_INFLATE));
    supply_ok_pin = 1'b1;
  endtask
  task automatic t_codes();
    logic [CODE_W-1:0] codes [7];
    codes = '{HELP_CAL, HELP_VALVE, HELP_ANALOG, HELP_TIMER, HELP_BCD, HELP_ROM, HELP_RAM};
    foreach (codes[i]) begin
      do_reset();
      repeat (8) @(negedge clk);
      fault_code = codes[i];
      fault_report = 1'b1;
      @(negedge clk);
      fault_report = 1'b0;
      repeat (2) @(negedge clk);
      chk({help_show, help_code}, {1'b1, codes[i]});
      chk({valve_power_en, valve}, 16'h0000);
    end
  endtask
  // a later report must not replace the watchdog code
  task automatic t_watchdog();
    do_reset();
    repeat (40) @(negedge clk);
    timer_fault_n = 1'b0;
    wait_for(3);
    @(negedge clk);
    chk({irq, valve_power_en, valve}, 16'h0080);
    irq_ack = 1'b1;
    @(negedge clk);
    irq_ack = 1'b0;
    fault_code = HELP_ROM;
    fault_report = 1'b1;
    @(negedge clk);
    fault_report = 1'b0;
    @(negedge clk);
    chk({irq, help_show, alarm_tone, help_code}, {3'h3, HELP_TIMER});
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    fetch_addr = '0;
    timer_fault_n = 1'b1;
    irq_ack = 1'b0;
    fault_report = 1'b0;
    fault_code = '0;
    supply_ok_pin = 1'b1;
    valve_req = 6'h3f;
    periph = '0;
    n_mismatch = 0;
    cmp_count = 0;
    do_reset();
    t_fetch(13'h1fff);
    t_fetch(13'h0aa5);
    t_access(1'b0, 16'hb000, 8'hc3);
    t_access(1'b1, 16'h5000, 8'h3c);
    t_fetch(13'h0000);
    t_supply();
    t_codes();
    t_watchdog();
    end_of_test();
  end
endmodule
`default_nettype wire
